// file: src/clid_defines.svh
// timing counts, addresses, field positions and reset values of the instruction decoder
`ifndef CLID_DEFINES_SVH
`define CLID_DEFINES_SVH

`define CLID_CLK_NS        4
`define CLID_EXEC_NS       18500
`define CLID_LONG_NS       760000
`define CLID_BLINK_NS      185000000
// least busy times round up, blink interval rounds down
`define CLID_EXEC_CYC      ((`CLID_EXEC_NS + `CLID_CLK_NS - 1) / `CLID_CLK_NS)
`define CLID_LONG_CYC      ((`CLID_LONG_NS + `CLID_CLK_NS - 1) / `CLID_CLK_NS)
`define CLID_BLINK_CYC     (`CLID_BLINK_NS / `CLID_CLK_NS)

`define CLID_SPACE_CODE    8'h20
`define CLID_ONE_LAST      7'h4F
`define CLID_L1_LAST       7'h27
`define CLID_L2_FIRST      7'h40
`define CLID_L2_LAST       7'h67
`define CLID_DRAM_LAST     7'h7F
`define CLID_SPAN_ONE      7'h50
`define CLID_SPAN_TWO      7'h28

`define CLID_BIT_WIDTH     4
`define CLID_BIT_LINES     3
`define CLID_BIT_FONT      2
`define CLID_BIT_SHSEL     3
`define CLID_BIT_SHDIR     2
`define CLID_BIT_DISP      2
`define CLID_BIT_CUR       1
`define CLID_BIT_BLINK     0
`define CLID_BIT_INC       1
`define CLID_BIT_SHEN      0

`define CLID_DUTY_8        2'h0
`define CLID_DUTY_11       2'h1
`define CLID_DUTY_16       2'h2

`define CLID_RST_WIDTH8    1'b1
`define CLID_RST_INC       1'b1

`endif

// file: src/clid_pkg.sv
// types and address helpers shared by the instruction decoder files
package clid_pkg;
  `include "clid_defines.svh"

  typedef logic [6:0] clid_addr_t;
  typedef logic [7:0] clid_byte_t;

  typedef enum logic [3:0] {
    CI_NONE, CI_CLEAR, CI_HOME, CI_ENTRY, CI_DISP,
    CI_SHIFT, CI_FUNC, CI_GLYPH_ADDR, CI_DRAM_ADDR
  } clid_instr_e;

  // highest set bit picks exactly one instruction
  function automatic clid_instr_e clid_decode(input clid_byte_t b);
    if (b[7])      return CI_DRAM_ADDR;
    else if (b[6]) return CI_GLYPH_ADDR;
    else if (b[5]) return CI_FUNC;
    else if (b[4]) return CI_SHIFT;
    else if (b[3]) return CI_DISP;
    else if (b[2]) return CI_ENTRY;
    else if (b[1]) return CI_HOME;
    else if (b[0]) return CI_CLEAR;
    else           return CI_NONE;
  endfunction

  // address counter step, jumping the gap between the two lines
  function automatic clid_addr_t clid_step(input clid_addr_t a, input logic up,
                                           input logic glyph, input logic two);
    if (glyph)
      return up ? {1'b0, a[5:0] + 6'h01} : {1'b0, a[5:0] - 6'h01};
    if (two) begin
      if (up)
        return (a == `CLID_L1_LAST) ? `CLID_L2_FIRST :
               (a == `CLID_L2_LAST) ? 7'h00 : a + 7'h01;
      return (a == `CLID_L2_FIRST) ? `CLID_L1_LAST :
             (a == 7'h00) ? `CLID_L2_LAST : a - 7'h01;
    end
    if (up)
      return (a == `CLID_ONE_LAST) ? 7'h00 : a + 7'h01;
    return (a == 7'h00) ? `CLID_ONE_LAST : a - 7'h01;
  endfunction

  // display window offset; every line moves by the same amount
  function automatic clid_addr_t clid_pan(input clid_addr_t o, input logic left,
                                          input logic two);
    clid_addr_t span;
    span = two ? `CLID_SPAN_TWO : `CLID_SPAN_ONE;
    if (left)
      return (o >= span - 7'h01) ? 7'h00 : o + 7'h01;
    return (o == 7'h00) ? span - 7'h01 : o - 7'h01;
  endfunction
endpackage

// file: src/clid_ram_if.sv
// port between the decoder and its character memory
`timescale 1ns/100ps
interface clid_ram_if;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// file: src/clid_ram.sv
// single-port character memory: display bytes low half, glyph rows high half
`timescale 1ns/100ps
module clid_ram #(
  parameter int DEPTH = 256
) (
  input  wire logic    clk,
  clid_ram_if.mem      port
);
  import clid_pkg::*;

  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_r;

  // read data always registered; contents carry no reset
  always_ff @(posedge clk) begin
    if (port.we)
      mem_q[port.addr] <= port.wdata;
    rdata_r <= mem_q[port.addr];
  end

  assign port.rdata = rdata_r;
endmodule

// file: src/clid_top.sv
// instruction decoder and execution control of the character display controller
//////////////////////////////////////////////////////////////////////////////
// Function
// [RULE1] clear: space into all display ram, counter zero, home, increment direction, 0.76 ms
// [RULE2] home: counter zero, undo display shift, ram untouched, low bit ignored, 0.76 ms
// [RULE3] entry direction bit: 1 steps counter up, 0 down, also for glyph ram
// [RULE4] shift-with-entry: display ram write shifts display by direction; else no shift
// [RULE5] display enable blanks or shows display, ram contents kept
// [RULE6] cursor enable shows or hides cursor, entry direction untouched
// [RULE7] blink enable alternates cursor cell all-lit and character every 185 ms
// [RULE8] shift instruction: cursor left/right with counter step, or display left/right
// [RULE9] display shift keeps counter and moves all lines together
// [RULE10] two-line mode: cursor past end of line one wraps to line two
// [RULE11] function set latches interface width: 1 eight-bit, 0 two nibbles
// [RULE12] host sets width bit to one when a serial interface is used
// [RULE13] line and font bits select one-line 1/8, 1/11, or two-line 1/16 duty
// [RULE14] bits 7:6 = 01 load six-bit glyph ram address into counter
// [RULE15] bit 7 set loads seven-bit display ram address into counter
// [RULE16] one-line mode display addresses run 0x00 to 0x4F contiguously
// [RULE17] two-line mode: 0x00-0x27 and 0x40-0x67, counter jumps the gap
// [RULE18] status read returns busy on bit 7 and counter on bits 6:0, no delay
// [RULE19] data write stores into selected ram, data read returns it; 18.5 us each
// [RULE20] counter moves by one in entry direction after every ram access; a data read while busy returns the byte but leaves the counter
// [RULE21] while busy the flag reads high and instructions are not accepted
// [RULE22] four-bit mode: high nibble first on upper lines, busy after second
// [RULE23] instruction decoded by its most significant set bit
// [RULE24] busy held for each instruction's execution time in clock cycles
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
`include "clid_defines.svh"
module clid_top #(
  parameter int EXEC_CYC  = `CLID_EXEC_CYC,
  parameter int LONG_CYC  = `CLID_LONG_CYC,
  parameter int BLINK_CYC = `CLID_BLINK_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              register_select,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  input  wire clid_pkg::clid_byte_t wr_data,
  output logic [7:0]             rd_data,
  output logic                   busy_flag,
  output clid_pkg::clid_addr_t   address_counter,
  output logic                   glyph_select,
  output logic                   display_on,
  output logic                   cursor_on,
  output logic                   cursor_all_lit,
  output clid_pkg::clid_addr_t   display_shift,
  output logic                   two_line_mode,
  output logic                   font_tall,
  output logic [1:0]             duty_code,
  output logic                   interface_width_bit,
  output logic                   entry_increment,
  output logic                   entry_shift
);
  import clid_pkg::*;

  localparam int BW = $clog2(LONG_CYC + 1);
  localparam int KW = $clog2(BLINK_CYC + 1);

  typedef struct packed {
    logic [BW-1:0] busy_cnt;
    logic          busy;
    logic [KW-1:0] blink_cnt;
    logic          blink_ph;
    clid_addr_t    ac;
    logic          glyph;
    logic          inc;
    logic          shift_en;
    logic          disp_on;
    logic          cur_on;
    logic          blink_on;
    logic          width8;
    logic          two_line;
    logic          font11;
    logic [1:0]    duty;
    clid_addr_t    pan;
    logic          wr_nib;
    logic [3:0]    wr_hi;
    logic          rd_nib;
    logic          clr_act;
    clid_addr_t    clr_addr;
    logic          mem_we;
    logic [7:0]    mem_addr;
    clid_byte_t    mem_wd;
    logic          fetch_req;
    logic [1:0]    fetch;
    clid_byte_t    dhr;
    clid_byte_t    rd_q;
  } clid_state_s;

  clid_state_s s_r;
  clid_state_s s_nxt;
  logic        rst_m_r;
  logic        rst_sync_r;

  clid_ram_if ram_if ();

  clid_ram #(
    .DEPTH (256)
  ) u_ram (
    .clk  (clk),
    .port (ram_if)
  );

  //////////////////////////////////////////////////////////////////////////////
  // reset release, two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r    <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_m_r    <= 1'b1;
      rst_sync_r <= rst_m_r;
    end
  end

  // glyph ram sits in the upper half of the shared memory
  function automatic logic [7:0] ram_loc(input clid_addr_t a, input logic g);
    return g ? {2'h2, a[5:0]} : {1'b0, a};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic       go;
    clid_byte_t b;
    clid_byte_t val;
    logic       rd_done;
    go      = 1'b0;
    b       = 8'h00;
    val     = 8'h00;
    rd_done = 1'b0;
    s_nxt   = s_r;

    s_nxt.mem_we = 1'b0;
    // read data cleared outside its cycle so a stale byte never looks fresh
    s_nxt.rd_q   = 8'h00;
    // prefetch pipe: address out, memory read, data register, three edges
    // behind the request; the busy time hides this from a polling host
    s_nxt.fetch  = {s_r.fetch[0], 1'b0};
    if (s_r.fetch[1])
      s_nxt.dhr = ram_if.rdata;

    // busy countdown: preloaded with the count minus one, so the flag stands
    // exactly the full count; a longer count only delays the next write
    if (s_r.busy) begin
      if (s_r.busy_cnt == '0)
        s_nxt.busy = 1'b0; // [RULE24]
      else
        s_nxt.busy_cnt = s_r.busy_cnt - BW'(1);
    end

    // clear walks the whole display half while busy masks all writes
    // all 128 cells, mapped or not, so the long busy must exceed 128 cycles
    if (s_r.clr_act) begin
      s_nxt.mem_we   = 1'b1; // [RULE1]
      s_nxt.mem_addr = {1'b0, s_r.clr_addr};
      s_nxt.mem_wd   = `CLID_SPACE_CODE;
      s_nxt.clr_addr = s_r.clr_addr + 7'h01;
      if (s_r.clr_addr == `CLID_DRAM_LAST)
        s_nxt.clr_act = 1'b0;
    end else if (s_r.fetch_req) begin
      // prefetch one cycle after any write so the two never collide
      s_nxt.fetch_req = 1'b0;
      s_nxt.mem_addr  = ram_loc(s_r.ac, s_r.glyph);
      s_nxt.fetch[0]  = 1'b1;
    end

    // blink timer idles at zero while blinking is off
    // re-enabling always starts on the stored character, not the lit cell
    if (!s_r.blink_on) begin
      s_nxt.blink_cnt = '0; // [RULE7]
      s_nxt.blink_ph  = 1'b0;
    end else if (s_r.blink_cnt == KW'(BLINK_CYC - 1)) begin
      s_nxt.blink_cnt = '0; // [RULE7]
      s_nxt.blink_ph  = ~s_r.blink_ph;
    end else begin
      s_nxt.blink_cnt = s_r.blink_cnt + KW'(1);
    end

    //////////////////////////////////////////////////////////////////////////
    // write strobes: nibble pairing, refused whole while busy
    // a refused first nibble is lost; the host polls before sending both halves
    if (wr_stb && !s_r.busy) begin // [RULE21]
      if (s_r.width8) begin
        go = 1'b1;
        b  = wr_data;
      end else if (!s_r.wr_nib) begin
        s_nxt.wr_hi  = wr_data[7:4]; // [RULE22]
        s_nxt.wr_nib = 1'b1;
      end else begin
        go           = 1'b1; // [RULE22]
        b            = {s_r.wr_hi, wr_data[7:4]};
        s_nxt.wr_nib = 1'b0;
      end
    end

    if (go) begin
      s_nxt.busy     = 1'b1; // [RULE24]
      s_nxt.busy_cnt = BW'(EXEC_CYC - 1);
      if (register_select) begin
        s_nxt.mem_we    = 1'b1; // [RULE19]
        s_nxt.mem_addr  = ram_loc(s_r.ac, s_r.glyph);
        s_nxt.mem_wd    = b;
        s_nxt.ac        = clid_step(s_r.ac, s_r.inc, s_r.glyph, s_r.two_line); // [RULE20]
        s_nxt.fetch_req = 1'b1;
        if (s_r.shift_en && !s_r.glyph)
          s_nxt.pan = clid_pan(s_r.pan, s_r.inc, s_r.two_line); // [RULE4]
      end else begin
        case (clid_decode(b)) // [RULE23]
          CI_CLEAR: begin
            s_nxt.busy_cnt = BW'(LONG_CYC - 1); // [RULE1]
            s_nxt.clr_act  = 1'b1;
            s_nxt.clr_addr = 7'h00;
            s_nxt.ac       = 7'h00;
            s_nxt.glyph    = 1'b0;
            s_nxt.pan      = 7'h00;
            s_nxt.inc      = 1'b1;
            s_nxt.fetch_req = 1'b1;
          end
          CI_HOME: begin
            s_nxt.busy_cnt = BW'(LONG_CYC - 1); // [RULE2]
            s_nxt.ac       = 7'h00;
            s_nxt.glyph    = 1'b0;
            s_nxt.pan      = 7'h00;
            s_nxt.fetch_req = 1'b1;
          end
          CI_ENTRY: begin
            s_nxt.inc      = b[`CLID_BIT_INC]; // [RULE3]
            s_nxt.shift_en = b[`CLID_BIT_SHEN]; // [RULE4]
          end
          CI_DISP: begin
            s_nxt.disp_on  = b[`CLID_BIT_DISP]; // [RULE5]
            s_nxt.cur_on   = b[`CLID_BIT_CUR]; // [RULE6]
            s_nxt.blink_on = b[`CLID_BIT_BLINK]; // [RULE7]
          end
          CI_SHIFT: begin
            if (b[`CLID_BIT_SHSEL]) begin
              // counter left alone; one offset serves every line
              s_nxt.pan = clid_pan(s_r.pan, !b[`CLID_BIT_SHDIR], s_r.two_line); // [RULE8] [RULE9]
            end else begin
              s_nxt.ac = clid_step(s_r.ac, b[`CLID_BIT_SHDIR], s_r.glyph, s_r.two_line); // [RULE8] [RULE10]
              s_nxt.fetch_req = 1'b1;
            end
          end
          CI_FUNC: begin
            s_nxt.width8   = b[`CLID_BIT_WIDTH]; // [RULE11]
            s_nxt.two_line = b[`CLID_BIT_LINES]; // [RULE13]
            // two-line mode always uses the short font
            s_nxt.font11   = b[`CLID_BIT_FONT] & ~b[`CLID_BIT_LINES];
            // toggles restart so a width change never leaves a half byte pending
            s_nxt.wr_nib   = 1'b0;
            s_nxt.rd_nib   = 1'b0;
            if (b[`CLID_BIT_LINES])
              s_nxt.duty = `CLID_DUTY_16; // [RULE13]
            else if (b[`CLID_BIT_FONT])
              s_nxt.duty = `CLID_DUTY_11;
            else
              s_nxt.duty = `CLID_DUTY_8;
          end
          CI_GLYPH_ADDR: begin
            s_nxt.ac        = {1'b0, b[5:0]}; // [RULE14]
            s_nxt.glyph     = 1'b1;
            s_nxt.fetch_req = 1'b1;
          end
          CI_DRAM_ADDR: begin
            // addresses outside the mapped lines still step, see clid_step
            s_nxt.ac        = b[6:0]; // [RULE15] [RULE16] [RULE17]
            s_nxt.glyph     = 1'b0;
            s_nxt.fetch_req = 1'b1;
          end
          default: begin
            // an all-zero code does nothing and leaves the flag low
            s_nxt.busy = 1'b0;
          end
        endcase
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // read strobes: status never waits, data reads advance only when idle
    // status and data reads share one nibble toggle; a stray single read in
    // four-bit mode swaps the halves of later reads until a function set
    if (rd_stb) begin
      val = register_select ? s_r.dhr : {s_r.busy, s_r.ac}; // [RULE18] [RULE19]
      if (s_r.width8) begin
        s_nxt.rd_q = val;
        rd_done    = 1'b1;
      end else begin
        s_nxt.rd_q   = s_r.rd_nib ? {val[3:0], 4'h0} : {val[7:4], 4'h0}; // [RULE22]
        s_nxt.rd_nib = ~s_r.rd_nib;
        rd_done      = s_r.rd_nib;
      end
      if (rd_done && register_select && !s_r.busy && !go) begin
        s_nxt.ac        = clid_step(s_r.ac, s_r.inc, s_r.glyph, s_r.two_line); // [RULE20]
        s_nxt.fetch_req = 1'b1;
        s_nxt.busy      = 1'b1; // [RULE19]
        s_nxt.busy_cnt  = BW'(EXEC_CYC - 1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  // reset leaves eight-bit width so the first function set arrives whole
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      s_r          <= '0;
      s_r.width8   <= `CLID_RST_WIDTH8;
      s_r.inc      <= `CLID_RST_INC;
      s_r.duty     <= `CLID_DUTY_8;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // memory port and outputs, all straight from flops
  assign ram_if.we    = s_r.mem_we;
  assign ram_if.addr  = s_r.mem_addr;
  assign ram_if.wdata = s_r.mem_wd;

  assign rd_data             = s_r.rd_q;
  assign busy_flag           = s_r.busy;
  assign address_counter     = s_r.ac;
  assign glyph_select        = s_r.glyph;
  assign display_on          = s_r.disp_on;
  assign cursor_on           = s_r.cur_on;
  // the all-lit phase only exists while blinking is on
  assign cursor_all_lit      = s_r.blink_ph;
  assign display_shift       = s_r.pan;
  assign two_line_mode       = s_r.two_line;
  assign font_tall           = s_r.font11;
  assign duty_code           = s_r.duty;
  assign interface_width_bit = s_r.width8;
  assign entry_increment     = s_r.inc;
  assign entry_shift         = s_r.shift_en;
endmodule

// file: test/clid_props.sv
// port-level assertions for the instruction decoder
`timescale 1ns/100ps
module clid_props #(
  parameter int EXEC_CYC = 8,
  parameter int LONG_CYC = 200
) (
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 register_select,
  input wire logic                 wr_stb,
  input wire logic                 rd_stb,
  input wire clid_pkg::clid_byte_t wr_data,
  input wire logic [7:0]           rd_data,
  input wire logic                 busy_flag,
  input wire clid_pkg::clid_addr_t address_counter,
  input wire logic                 glyph_select,
  input wire clid_pkg::clid_addr_t display_shift,
  input wire logic                 two_line_mode,
  input wire logic                 font_tall,
  input wire logic [1:0]           duty_code,
  input wire logic                 interface_width_bit,
  input wire logic                 entry_increment
);
  import clid_pkg::*;
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  logic        take_w;
  logic        take_i;
  // nibble transfers are left to the bench, only whole bytes here
  assign take_w       = wr_stb && !busy_flag && interface_width_bit;
  assign take_i       = take_w && !register_select;
  assign busy_cnt_nxt = busy_flag ? busy_cnt_r + 32'h1 : 32'h0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_r <= 32'h0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////////
  busy_rise_a: assert property (
    take_w && (register_select || wr_data != 8'h00) |=> busy_flag) else $error("no busy");
  busy_len_a: assert property (
    $fell(busy_flag) |-> busy_cnt_r == EXEC_CYC || busy_cnt_r == LONG_CYC)
    else $error("busy length wrong");
  refuse_a: assert property (
    wr_stb && busy_flag |=> $stable(address_counter) && $stable(glyph_select))
    else $error("write taken while busy");
  status_a: assert property (
    rd_stb && !register_select && interface_width_bit
    |=> rd_data == {$past(busy_flag), $past(address_counter)}) else $error("status read");
  dram_load_a: assert property (
    take_i && wr_data[7] |=> address_counter == $past(wr_data[6:0]) && !glyph_select)
    else $error("display address load");
  glyph_load_a: assert property (
    take_i && wr_data[7:6] == 2'h1
    |=> address_counter == {1'b0, $past(wr_data[5:0])} && glyph_select)
    else $error("glyph address load");
  clear_a: assert property (
    take_i && wr_data == 8'h01
    |=> address_counter == 7'h00 && entry_increment && display_shift == 7'h00)
    else $error("clear");
  home_a: assert property (
    take_i && wr_data[7:1] == 7'h01
    |=> address_counter == 7'h00 && display_shift == 7'h00 && $stable(entry_increment))
    else $error("home");
  pan_a: assert property (
    take_i && wr_data[7:3] == 5'h03
    |=> $stable(address_counter) && display_shift != $past(display_shift))
    else $error("display shift");
  step_up_a: assert property (
    take_w && register_select && entry_increment && !glyph_select && !two_line_mode
    && address_counter < 7'h4F |=> address_counter == $past(address_counter) + 7'h01)
    else $error("counter step");
  duty_a: assert property (
    duty_code == (two_line_mode ? 2'h2 : {1'b0, font_tall})) else $error("duty");
endmodule
bind clid_top clid_props #(.EXEC_CYC(EXEC_CYC), .LONG_CYC(LONG_CYC)) u_props (
  .clk(clk), .rst_b(rst_b), .register_select(register_select), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data), .busy_flag(busy_flag),
  .address_counter(address_counter), .glyph_select(glyph_select),
  .display_shift(display_shift), .two_line_mode(two_line_mode), .font_tall(font_tall),
  .duty_code(duty_code), .interface_width_bit(interface_width_bit),
  .entry_increment(entry_increment)
);

// file: test/clid_host.sv
// host processor model: drives the decoder bus and polls busy
`timescale 1ns/100ps
module clid_host (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            register_select,
  output logic            wr_stb,
  output logic            rd_stb,
  output logic [7:0]      wr_data
);
  logic four_bit = 1'b0;
  initial begin
    register_select = 1'b0;
    wr_stb          = 1'b0;
    rd_stb          = 1'b0;
    wr_data         = 8'h00;
  end
  // raw write, no polling; released data lines show the inverse
  task automatic put(input logic rs, input logic [7:0] b);
    for (int i = 0; i < (four_bit ? 2 : 1); i++) begin
      @(posedge clk);
      register_select <= rs;
      wr_stb          <= 1'b1;
      wr_data         <= (four_bit && i == 1) ? {b[3:0], 4'h0} : b;
      @(posedge clk);
      wr_stb          <= 1'b0;
      wr_data         <= ~b;
    end
  endtask
  task automatic get(input logic rs, output logic [7:0] d);
    for (int i = 0; i < (four_bit ? 2 : 1); i++) begin
      @(posedge clk);
      register_select <= rs;
      rd_stb          <= 1'b1;
      @(posedge clk);
      rd_stb          <= 1'b0;
      #1;
      d = !four_bit ? rd_data : (i == 0) ? {rd_data[7:4], 4'h0} : {d[7:4], rd_data[7:4]};
    end
  endtask
  // polls with no limit of its own; the bench watchdog ends a hang
  task automatic ready();
    logic [7:0] s;
    do begin
      get(1'b0, s);
    end while (s[7] !== 1'b0);
  endtask
  task automatic wr(input logic rs, input logic [7:0] b);
    ready();
    put(rs, b);
  endtask
endmodule

// file: test/tb.sv
// self-checking bench for the instruction decoder
`timescale 1ns/100ps
module tb;
  import clid_pkg::*;
  localparam int LONG  = 200;
  localparam int BLINK = 16;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       rs, wr_stb, rd_stb, busy_flag, glyph_select, display_on, cursor_on;
  logic       cursor_all_lit, two_line_mode, font_tall, interface_width_bit;
  logic       entry_increment, entry_shift;
  logic [7:0] wr_data, rd_data, s;
  logic [1:0] duty_code;
  clid_addr_t address_counter, display_shift;
  int         errors = 0;
  int         tests_run = 0;
  int         seen;
  // row: instruction, counter, window offset, mode bits
  logic [30:0] rows [17] = '{
    {8'h0F, 7'h00, 7'h00, 9'h0C2}, {8'h34, 7'h00, 7'h00, 9'h0D6},
    {8'h38, 7'h00, 7'h00, 9'h0EA}, {8'h05, 7'h00, 7'h00, 9'h0E9},
    {8'h06, 7'h00, 7'h00, 9'h0EA}, {8'hA7, 7'h27, 7'h00, 9'h0EA},
    {8'h14, 7'h40, 7'h00, 9'h0EA}, {8'h10, 7'h27, 7'h00, 9'h0EA},
    {8'h18, 7'h27, 7'h01, 9'h0EA}, {8'h1C, 7'h27, 7'h00, 9'h0EA},
    {8'h1C, 7'h27, 7'h27, 9'h0EA}, {8'h02, 7'h00, 7'h00, 9'h0EA},
    {8'h4A, 7'h0A, 7'h00, 9'h1EA}, {8'h08, 7'h0A, 7'h00, 9'h12A},
    {8'h0C, 7'h0A, 7'h00, 9'h1AA}, {8'h00, 7'h0A, 7'h00, 9'h1AA},
    {8'h30, 7'h0A, 7'h00, 9'h182}};

  clid_top #(.EXEC_CYC(8), .LONG_CYC(LONG), .BLINK_CYC(BLINK)) dut (
    .clk(clk), .rst_b(rst_b), .register_select(rs), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wr_data(wr_data), .rd_data(rd_data), .busy_flag(busy_flag),
    .address_counter(address_counter), .glyph_select(glyph_select),
    .display_on(display_on), .cursor_on(cursor_on), .cursor_all_lit(cursor_all_lit),
    .display_shift(display_shift), .two_line_mode(two_line_mode), .font_tall(font_tall),
    .duty_code(duty_code), .interface_width_bit(interface_width_bit),
    .entry_increment(entry_increment), .entry_shift(entry_shift));
  clid_host h (.clk(clk), .rd_data(rd_data), .register_select(rs), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .wr_data(wr_data));

  initial begin
    forever #2 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic lit(input int n);
    seen = 0;
    repeat (n) begin
      @(negedge clk);
      if (cursor_all_lit === 1'b1) seen++;
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // generous: the whole run needs about a thousand cycles
  initial begin
    #100000;
    errors++;
    $display("Error watchdog expired");
    test_done();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("reset", 13'h0018, {busy_flag, address_counter, interface_width_bit,
        entry_increment, duty_code, display_on});
    $display("test reset done");
    foreach (rows[i]) begin
      h.wr(1'b0, rows[i][30:23]);
      h.ready();
      h.get(1'b0, s);
      chk("counter", rows[i][22:16], s[6:0]);
      chk("offset", rows[i][15:9], display_shift);
      chk("mode", rows[i][8:0], {glyph_select, display_on, cursor_on, two_line_mode,
          font_tall, duty_code, entry_increment, entry_shift});
    end
    $display("test instruction rows done");
    h.wr(1'b0, 8'hCF);
    h.wr(1'b1, 8'h41);
    h.ready();
    chk("wrap", 7'h00, address_counter);
    h.wr(1'b0, 8'hCF);
    h.ready();
    h.get(1'b1, s);
    chk("ram read", 8'h41, s);
    $display("test ram access done");
    h.wr(1'b0, 8'h07);
    h.wr(1'b1, 8'h42);
    h.ready();
    chk("entry pan", 14'h0081, {address_counter, display_shift});
    h.wr(1'b0, 8'h7F);
    h.wr(1'b1, 8'h1F);
    h.ready();
    chk("glyph step", 14'h0001, {address_counter, display_shift});
    $display("test entry shift done");
    h.wr(1'b0, 8'h04);
    h.wr(1'b0, 8'h01);
    h.put(1'b0, 8'hB3);
    h.ready();
    chk("clear", 15'h4000, {entry_increment, address_counter, display_shift});
    h.wr(1'b0, 8'hCF);
    h.ready();
    h.get(1'b1, s);
    chk("space", 8'h20, s);
    $display("test clear done");
    h.wr(1'b0, 8'h0D);
    h.ready();
    lit(3 * BLINK);
    chk("blink", 1'b1, seen > 0);
    h.wr(1'b0, 8'h0C);
    h.ready();
    lit(2 * BLINK);
    chk("blink off", 0, seen);
    $display("test blink done");
    h.wr(1'b0, 8'h28);
    // status reads pair up from the edge that drops the width bit
    h.four_bit = 1'b1;
    h.ready();
    chk("width", 1'b0, interface_width_bit);
    h.wr(1'b0, 8'hC5);
    h.ready();
    h.get(1'b0, s);
    chk("nibble", 8'h45, s);
    h.wr(1'b0, 8'h30);
    h.four_bit = 1'b0;
    h.ready();
    chk("width", 1'b1, interface_width_bit);
    $display("test four-bit done");
    test_done();
  end
endmodule
